//--- rtl/sld_defines.vh
// Constants of the static segment driver: sizes, bit positions, timing.
`ifndef SLD_DEFINES_VH
`define SLD_DEFINES_VH

// ============================================================
// Display geometry
`define SLD_SEG_COUNT      40
`define SLD_LOW_GROUP_LAST 16

// ============================================================
// Bit positions of the synchronised pin vector
`define SLD_PIN_SCLK   0
`define SLD_PIN_SDIN   1
`define SLD_PIN_LATCH  2
`define SLD_PIN_DIVCK  3
`define SLD_PIN_FRAME  4
`define SLD_PIN_BLINK  5
`define SLD_PIN_OSCEN  6
`define SLD_PIN_BEN    7
`define SLD_PIN_SEN_LO 8
`define SLD_PIN_SEN_HI 9
`define SLD_PIN_CEN_A  10
`define SLD_PIN_CEN_B  11
`define SLD_PIN_COUNT  12

// ============================================================
// Divider: counter bit k toggles at the input rate over 2^(k+1)
`define SLD_DIV_WIDTH  15
`define SLD_DIV16_BIT  3
`define SLD_DIV256_BIT 7
`define SLD_DIV8K_BIT  12
`define SLD_DIV32K_BIT 14

// ============================================================
// Timing of the internal oscillator
`define SLD_CLOCK_HZ        25000000
`define SLD_OSC_HZ          32000
`define SLD_OSC_HALF_CYCLES (`SLD_CLOCK_HZ / (2 * `SLD_OSC_HZ))
`define SLD_OSC_CNT_WIDTH   9

// ============================================================
// Serial input buffer and reset values
`define SLD_FIFO_DEPTH    32
`define SLD_FIFO_ADDR_W   5
`define SLD_DATA_RESET    40'h00_0000_0000
`define SLD_PIN_RESET     12'h000
`define SLD_DIV_RESET     15'h0000

`endif

//--- rtl/sld_driver.v
// Static 40-segment driver with serial input buffer, divider and blink.
`include "sld_defines.vh"

// ============================================================
// Serial bit buffer
module sld_fifo #(
    parameter WIDTH  = 1,
    parameter DEPTH  = `SLD_FIFO_DEPTH,
    parameter ADDR_W = `SLD_FIFO_ADDR_W
) (
    input  wire              clock,
    input  wire              rst_n,
    input  wire              in_valid,
    output wire              in_ready,
    input  wire [WIDTH-1:0]  in_data,
    output wire              out_valid,
    input  wire              out_ready,
    output wire [WIDTH-1:0]  out_data,
    output wire [ADDR_W:0]   count
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr_reg;
    reg [ADDR_W-1:0] rd_ptr_reg;
    reg [ADDR_W:0]   count_reg;
    wire             push;
    wire             pop;

    // Full and empty follow the occupancy count, so both stay honest.
    assign in_ready  = (count_reg != DEPTH[ADDR_W:0]);
    assign out_valid = (count_reg != {(ADDR_W+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_reg];
    assign count     = count_reg;

    // Storage has no reset; only pointers and count are control state.
    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap naturally since depth is a power of two.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {ADDR_W{1'b0}};
            rd_ptr_reg <= {ADDR_W{1'b0}};
            count_reg  <= {(ADDR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ============================================================
// Top level
module sld_driver #(
    parameter SEG_COUNT  = `SLD_SEG_COUNT,
    parameter LOW_LAST   = `SLD_LOW_GROUP_LAST,
    parameter FIFO_DEPTH = `SLD_FIFO_DEPTH,
    parameter FIFO_AW    = `SLD_FIFO_ADDR_W
) (
    input  wire                 clock,
    input  wire                 rst_n,
    input  wire                 shift_clock,
    input  wire                 serial_in_line,
    input  wire                 latch,
    input  wire                 divider_clock_in,
    input  wire                 lcd_frame_clock,
    input  wire                 blink_rate_clock,
    input  wire                 oscillator_enable_low,
    input  wire                 blink_enable_low,
    input  wire                 low_segment_group_enable,
    input  wire                 high_segment_group_enable,
    input  wire                 common_a_enable,
    input  wire                 common_b_enable,
    output reg                  oscillator_output,
    output reg  [4:0]           frame_clock_taps,
    output reg  [2:0]           blink_clock_taps,
    output reg                  serial_chain_out,
    output reg                  serial_ready,
    output reg                  common_out_a,
    output reg                  common_out_b,
    output reg  [SEG_COUNT-1:0] segment_out
);
    wire [`SLD_PIN_COUNT-1:0]     pins_raw;
    reg  [`SLD_PIN_COUNT-1:0]     sync1_reg;
    reg  [`SLD_PIN_COUNT-1:0]     sync2_reg;
    reg  [`SLD_PIN_COUNT-1:0]     prev_reg;
    wire                          shift_rise;
    wire                          latch_rise;
    wire                          divck_rise;
    wire                          frame_edge;
    reg  [`SLD_OSC_CNT_WIDTH-1:0] osc_cnt_reg;
    reg  [`SLD_DIV_WIDTH-1:0]     div_cnt_reg;
    reg  [SEG_COUNT-1:0]          shift_reg;
    reg  [SEG_COUNT-1:0]          data_reg;
    reg                           latch_pending_reg;
    reg  [FIFO_AW:0]              ahead_reg;
    reg  [FIFO_AW:0]              ahead_next;
    wire                          copy_now;
    wire                          fifo_in_ready;
    wire                          fifo_out_valid;
    wire                          fifo_out_ready;
    wire                          fifo_out_data;
    wire [FIFO_AW:0]              fifo_count;
    wire                          pop;
    wire                          frame;
    wire                          blank;
    wire                          seg_lo_on;
    wire                          seg_hi_on;

    // ============================================================
    // Pin synchronisers
    assign pins_raw = {common_b_enable, common_a_enable,
                       high_segment_group_enable, low_segment_group_enable,
                       blink_enable_low, oscillator_enable_low,
                       blink_rate_clock, lcd_frame_clock, divider_clock_in,
                       latch, serial_in_line, shift_clock};

    // Every pin is asynchronous to clock; prev_reg feeds edge detection.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `SLD_PIN_RESET;
            sync2_reg <= `SLD_PIN_RESET;
            prev_reg  <= `SLD_PIN_RESET;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign shift_rise = sync2_reg[`SLD_PIN_SCLK] & ~prev_reg[`SLD_PIN_SCLK];
    assign latch_rise = sync2_reg[`SLD_PIN_LATCH]
                        & ~prev_reg[`SLD_PIN_LATCH];
    assign divck_rise = sync2_reg[`SLD_PIN_DIVCK]
                        & ~prev_reg[`SLD_PIN_DIVCK];
    assign frame_edge = sync2_reg[`SLD_PIN_FRAME]
                        ^ prev_reg[`SLD_PIN_FRAME];

    // ============================================================
    // Internal oscillator
    // Toggles every half period while its enable is low; held low
    // otherwise so that an external clock can own the divider input.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_reg       <= {`SLD_OSC_CNT_WIDTH{1'b0}};
            oscillator_output <= 1'b0;
        end else if (sync2_reg[`SLD_PIN_OSCEN]) begin
            osc_cnt_reg       <= {`SLD_OSC_CNT_WIDTH{1'b0}};
            oscillator_output <= 1'b0;
        end else if (osc_cnt_reg ==
                     `SLD_OSC_HALF_CYCLES - 1) begin
            osc_cnt_reg       <= {`SLD_OSC_CNT_WIDTH{1'b0}};
            oscillator_output <= ~oscillator_output;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 1'b1;
        end
    end

    // ============================================================
    // Frequency divider
    // Counts rises of the divider input; each tap is one counter bit.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg      <= `SLD_DIV_RESET;
            frame_clock_taps <= 5'h00;
            blink_clock_taps <= 3'h0;
        end else begin
            if (divck_rise) begin
                div_cnt_reg <= div_cnt_reg + 1'b1;
            end
            frame_clock_taps <=
                div_cnt_reg[`SLD_DIV256_BIT:`SLD_DIV16_BIT];
            blink_clock_taps <=
                div_cnt_reg[`SLD_DIV32K_BIT:`SLD_DIV8K_BIT];
        end
    end

    // ============================================================
    // Serial input path
    // The buffer absorbs shift-clock bits while a latch copy stalls
    // the drain; the bit pins cannot be held, so ready is reported.
    sld_fifo #(
        .WIDTH  (1),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (shift_rise),
        .in_ready  (fifo_in_ready),
        .in_data   (sync2_reg[`SLD_PIN_SDIN]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    assign copy_now       = latch_pending_reg
                            & (ahead_reg == {(FIFO_AW+1){1'b0}});
    assign fifo_out_ready = ~copy_now;
    assign pop            = fifo_out_valid & fifo_out_ready;

    // Bits that arrived before the latch rise must be shifted first.
    always @* begin
        ahead_next = ahead_reg;
        if (latch_rise && !latch_pending_reg) begin
            ahead_next = fifo_count
                         + {{FIFO_AW{1'b0}}, shift_rise & fifo_in_ready}
                         - {{FIFO_AW{1'b0}}, pop};
        end else if (pop && latch_pending_reg &&
                     ahead_reg != {(FIFO_AW+1){1'b0}}) begin
            ahead_next = ahead_reg - 1'b1;
        end
    end

    // Shift in at bit 0 so the first bit sent reaches the last segment.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg         <= `SLD_DATA_RESET;
            data_reg          <= `SLD_DATA_RESET;
            serial_chain_out  <= 1'b0;
            serial_ready      <= 1'b0;
            latch_pending_reg <= 1'b0;
            ahead_reg         <= {(FIFO_AW+1){1'b0}};
        end else begin
            serial_ready <= fifo_in_ready;
            ahead_reg    <= ahead_next;
            if (pop) begin
                shift_reg        <= {shift_reg[SEG_COUNT-2:0],
                                     fifo_out_data};
                serial_chain_out <= shift_reg[SEG_COUNT-1];
            end
            if (copy_now) begin
                data_reg          <= shift_reg;
                latch_pending_reg <= 1'b0;
            end else if (latch_rise) begin
                latch_pending_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // Output drive
    assign frame     = sync2_reg[`SLD_PIN_FRAME];
    // Blink off phase is the low half of the blink clock.
    assign blank     = ~sync2_reg[`SLD_PIN_BEN]
                       & ~sync2_reg[`SLD_PIN_BLINK];
    assign seg_lo_on = ~sync2_reg[`SLD_PIN_SEN_LO];
    assign seg_hi_on = ~sync2_reg[`SLD_PIN_SEN_HI];

    // Commons update only on frame edges, so a latch cannot glitch them.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            common_out_a <= 1'b0;
            common_out_b <= 1'b0;
        end else if (frame_edge) begin
            common_out_a <= ~sync2_reg[`SLD_PIN_CEN_A]
                            & ~frame;
            common_out_b <= ~sync2_reg[`SLD_PIN_CEN_B]
                            & ~frame;
        end
    end

    // One flip-flop per segment; a lit segment follows the frame clock.
    genvar i;
    generate
        for (i = 0; i < SEG_COUNT; i = i + 1) begin : g_seg
            wire group_on;
            assign group_on = (i < LOW_LAST) ? seg_lo_on : seg_hi_on;
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    segment_out[i] <= 1'b0;
                end else if (frame_edge) begin
                    segment_out[i] <= group_on
                        & ((data_reg[i] & ~blank) ? frame
                                                  : ~frame);
                end
            end
        end
    endgenerate
endmodule

//--- verification/sld_driver_sva.sv
// Checker of segment, common and oscillator timing at the driver ports.
// ============================================================
// Checker
module sld_driver_sva #(
    parameter SEG_COUNT = 40,
    parameter LOW_LAST  = 16
) (
    input wire                 clock,
    input wire                 rst_n,
    input wire                 lcd_frame_clock,
    input wire                 blink_rate_clock,
    input wire                 oscillator_enable_low,
    input wire                 blink_enable_low,
    input wire                 low_segment_group_enable,
    input wire                 high_segment_group_enable,
    input wire                 common_a_enable,
    input wire                 common_b_enable,
    input wire                 oscillator_output,
    input wire                 common_out_a,
    input wire                 common_out_b,
    input wire [SEG_COUNT-1:0] segment_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] frame_age_reg;
    logic [8:0] osc_run_reg;
    logic       settled;

    // Outputs follow a frame pin edge only after the synchronisers, so the
    // age of the frame level says when an output may legally move.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_age_reg <= 4'hf;
            osc_run_reg   <= 9'h000;
        end else begin
            frame_age_reg <= $changed(lcd_frame_clock) ? 4'h0
                : frame_age_reg + {3'h0, frame_age_reg != 4'hf};
            osc_run_reg   <= $changed(oscillator_output) ? 9'h000
                : osc_run_reg + 9'h001;
        end
    end
    assign settled = (frame_age_reg == 4'h6);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Output relations sampled once a frame edge has fully propagated; the glitch and oscillator checks below run every cycle.
    property p_com_a;
        settled |-> common_out_a == (!lcd_frame_clock && !common_a_enable);
    endproperty
    a_com_a: assert property (p_com_a) else $error("com a wrong");
    property p_com_b;
        settled |-> common_out_b == (!lcd_frame_clock && !common_b_enable);
    endproperty
    a_com_b: assert property (p_com_b) else $error("com b wrong");
    property p_seg_low;
        settled && low_segment_group_enable
            |-> segment_out[LOW_LAST-1:0] == '0;
    endproperty
    a_seg_low: assert property (p_seg_low) else $error("low group");
    property p_seg_high;
        settled && high_segment_group_enable
            |-> segment_out[SEG_COUNT-1:LOW_LAST] == '0;
    endproperty
    a_seg_high: assert property (p_seg_high) else $error("hi group");
    property p_blank;
        settled && !blink_enable_low && !blink_rate_clock
            && !low_segment_group_enable && !high_segment_group_enable
            |-> segment_out == {SEG_COUNT{!lcd_frame_clock}};
    endproperty
    a_blank: assert property (p_blank) else $error("blank phase");
    property p_frame_sync;
        $changed({common_out_a, common_out_b, segment_out})
            |-> frame_age_reg >= 4'h2 && frame_age_reg <= 4'h6;
    endproperty
    a_frame_sync: assert property (p_frame_sync) else $error("glitch");
    property p_osc_stop;
        oscillator_enable_low [*6] |-> !oscillator_output;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc runs");
    property p_osc_half;
        $fell(oscillator_output) && !oscillator_enable_low
            |-> osc_run_reg == 9'h185;
    endproperty
    a_osc_half: assert property (p_osc_half) else $error("osc rate");

    c_blank: cover property (settled && !blink_enable_low && !blink_rate_clock);
    c_com_off: cover property (settled && common_a_enable);
    c_osc: cover property ($fell(oscillator_output));
endmodule

bind sld_driver sld_driver_sva #(.SEG_COUNT(SEG_COUNT), .LOW_LAST(LOW_LAST))
    u_sva (.clock(clock), .rst_n(rst_n), .lcd_frame_clock(lcd_frame_clock),
    .blink_rate_clock(blink_rate_clock),
    .oscillator_enable_low(oscillator_enable_low),
    .blink_enable_low(blink_enable_low),
    .low_segment_group_enable(low_segment_group_enable),
    .high_segment_group_enable(high_segment_group_enable),
    .common_a_enable(common_a_enable), .common_b_enable(common_b_enable),
    .oscillator_output(oscillator_output), .common_out_a(common_out_a),
    .common_out_b(common_out_b), .segment_out(segment_out));

//--- verification/sld_host_model.sv
// Host side of the serial link: shifts display words, pulses the latch.
module sld_host_model (
    input  wire logic clock,
    output logic      shift_clock,
    output logic      serial_in_line,
    output logic      latch,
    input  wire logic serial_chain_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // The shift clock stands still between words.
    initial begin
        shift_clock    = 1'b0;
        serial_in_line = 1'b0;
        latch          = 1'b0;
    end

    // Waits a number of rising clock edges.
    task automatic tick(input int cnt);
        repeat (cnt) @(posedge clock);
    endtask

    // Sends last segment first; the bit leaving stage 40 is kept so that
    // word_out returns the previous register contents in segment order.
    task automatic send_word(input logic [39:0] word,
                             output logic [39:0] word_out);
        for (int i = 39; i >= 0; i--) begin
            serial_in_line <= word[i];
            tick(5);
            shift_clock <= 1'b1;
            tick(10);
            word_out[i] = serial_chain_out;
            shift_clock <= 1'b0;
            tick(3);
            // Past hold time the line means nothing, so show the opposite
            // level: a late sample then cannot pass by luck.
            serial_in_line <= ~word[i];
            tick(2);
        end
    endtask

    // One latch pulse, long enough for the pin synchronisers.
    task automatic pulse_latch();
        latch <= 1'b1;
        tick(10);
        latch <= 1'b0;
        tick(10);
    endtask
endmodule

//--- verification/tb_sld_driver.sv
// Bench of the static segment driver: serial load, frame drive, divider.
module tb_sld_driver;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [39:0] W_P = 40'hc3_5a96_0f81;
    localparam logic [39:0] W_Q = 40'h12_3456_789a;
    logic clock, shk, sdat, ltch, osc_out, chain, ready, com_a, com_b;
    logic rst_n = 1'b0, dvin = 1'b0, frm = 1'b0, brc = 1'b1, v = 1'b0;
    logic osc_off = 1'b0, blink_off = 1'b1, grp_lo = 1'b0, grp_hi = 1'b0;
    logic com_a_off = 1'b0, com_b_off = 1'b0;
    logic [4:0]  f_taps;
    logic [2:0]  b_taps;
    logic [3:0]  en = 4'h0;
    logic [39:0] seg, seen;
    int          n, err_total = 0, samples_checked = 0;

    sld_driver uut (
        .clock(clock), .rst_n(rst_n), .shift_clock(shk),
        .serial_in_line(sdat), .latch(ltch), .divider_clock_in(dvin),
        .lcd_frame_clock(frm), .blink_rate_clock(brc),
        .oscillator_enable_low(osc_off), .blink_enable_low(blink_off),
        .low_segment_group_enable(grp_lo),
        .high_segment_group_enable(grp_hi),
        .common_a_enable(com_a_off), .common_b_enable(com_b_off),
        .oscillator_output(osc_out), .frame_clock_taps(f_taps),
        .blink_clock_taps(b_taps), .serial_chain_out(chain),
        .serial_ready(ready), .common_out_a(com_a), .common_out_b(com_b),
        .segment_out(seg));
    sld_host_model host (.clock(clock), .shift_clock(shk),
        .serial_in_line(sdat), .latch(ltch), .serial_chain_out(chain));

    // ============================================================
    // Clock and helpers
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string what, input logic [39:0] seen_v,
                       input logic [39:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Counts edges while the oscillator holds lvl; a hang ends the run.
    task automatic wait_osc(input logic lvl);
        n = 0;
        while (osc_out === lvl && n < 1000) begin
            @(posedge clock);
            n++;
        end
        if (n == 1000) begin
            err_total++;
            summarize();
        end
    endtask

    // Frame edges are spaced so every output settles before a check.
    task automatic frame(input logic lvl);
        frm <= lvl;
        repeat (12) @(posedge clock);
    endtask

    task automatic div_pulses(input int cnt);
        repeat (cnt) begin
            dvin <= 1'b1;
            repeat (4) @(posedge clock);
            dvin <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk("seg reset", seg, '0);
        chk("chain reset", 40'(chain), '0);
        chk("ready", 40'(ready), 40'h1);
        wait_osc(1'b0);
        wait_osc(1'b1);
        chk("osc half", 40'(n), 40'h186);
        host.send_word(W_P, seen);
        chk("chain first", seen, '0);
        host.pulse_latch();
        frame(1'b1);
        chk("seg P", seg, W_P);
        chk("com a", 40'(com_a), '0);
        frame(1'b0);
        chk("seg inv P", seg, ~W_P);
        chk("com b", 40'(com_b), 40'h1);
        host.send_word(W_Q, seen);
        chk("chain out", seen, W_P);
        frame(1'b1);
        chk("seg held", seg, W_P);
        host.pulse_latch();
        frame(1'b0);
        chk("seg inv Q", seg, ~W_Q);
        // Each group and common disable pin in turn, on alternating frame levels.
        for (int k = 0; k < 4; k++) begin
            en = 4'h8 >> k;
            {grp_lo, grp_hi, com_a_off, com_b_off} <= en;
            v = ~v;
            frame(v);
            chk("seg group", seg,
                (v ? W_Q : ~W_Q) & {{24{!en[2]}}, {16{!en[3]}}});
            chk("com pair", 40'({com_a, com_b}),
                40'({2{!v}} & ~en[1:0]));
        end
        {grp_lo, grp_hi, com_a_off, com_b_off} <= 4'h0;
        blink_off <= 1'b0;
        brc <= 1'b0;
        frame(1'b1);
        chk("blank hi", seg, '0);
        frame(1'b0);
        chk("blank lo", seg, '1);
        brc <= 1'b1;
        frame(1'b1);
        chk("blink shown", seg, W_Q);
        blink_off <= 1'b1;
        brc <= 1'b0;
        frame(1'b0);
        chk("blink off", seg, ~W_Q);
        osc_off <= 1'b1;
        repeat (20) @(posedge clock);
        chk("osc stop", 40'(osc_out), '0);
        div_pulses(24);
        chk("frame taps", 40'(f_taps), 40'h3);
        chk("blink taps", 40'(b_taps), '0);
        div_pulses(4096);
        chk("frame taps", 40'(f_taps), 40'h3);
        chk("blink taps", 40'(b_taps), 40'h1);
        summarize();
    end
endmodule
